// File: rtl/dimming_pwm_consts.vh
`ifndef DIMMING_PWM_CONSTS_VH
`define DIMMING_PWM_CONSTS_VH

// register map, byte-wide registers on the plain register port
`define ADDR_HIGH_BASE 8'h00
`define ADDR_LOW_BASE 8'h10
`define ADDR_CTRL 8'h20
`define ADDR_RATE 8'h21
`define ADDR_EN_LO 8'h22
`define ADDR_EN_HI 8'h23
`define ADDR_STATUS 8'h24

// control register fields
`define CTRL_CURVE_BIT 0
`define CTRL_COMMON_BIT 1
`define CTRL_EXT_BIT 2

// reset values
`define LOW_NIBBLE_RESET 4'hF
`define EN_RESET 12'h000
`define CTRL_RESET 8'h00
`define CTRL_COMMON_RESET 1'b0
`define CTRL_EXT_RESET 1'b0

// timing
`define NUM_CH 12
`define PERIOD_PULSES 256
`define REF_CLK_HZ 250000000

`endif

// File: rtl/exp_curve_rom.v
`timescale 1ns/1ps
`default_nettype none

// exponential brightness curve: eight octaves of 32 steps, strictly rising
module exp_curve_rom (
	input wire [7:0] index_in,
	output wire [11:0] code_out
);

	wire [2:0] octave;
	wire [4:0] step;
	wire [2:0] shift;
	wire [11:0] mant;
	wire [11:0] scaled;

	assign octave = index_in[7:5];
	assign step = index_in[4:0];
	assign shift = octave - 3'h1;
	assign mant = {6'h00, 1'b1, step};
	assign scaled = mant << shift;
	// octave 0 stays linear so no two indices share a code; 255 maps to 4032
	assign code_out = (octave == 3'h0) ? {7'h00, step} : scaled;

endmodule

`default_nettype wire

// File: rtl/pwm_channel.v
`timescale 1ns/1ps
`default_nettype none

module pwm_channel (
	input wire ref_clk_in,
	input wire rst_n_in,
	input wire period_wrap_in,
	input wire [7:0] pulse_cnt_in,
	input wire [3:0] frame_in,
	input wire [11:0] duty_code_in,
	output reg pwm_on_out
);

	reg [11:0] code_ff;
	wire [3:0] frame_rev;
	wire extend;
	wire [8:0] on_pulses;

	// code is taken only at a period boundary so a period is never cut short
	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			code_ff <= 12'h000;
		else if (period_wrap_in)
			code_ff <= duty_code_in;
	end

	// bit reversal spreads the extended periods evenly over 16
	assign frame_rev = {frame_in[0], frame_in[1], frame_in[2], frame_in[3]};
	assign extend = (frame_rev <= code_ff[3:0]);
	assign on_pulses = {1'b0, code_ff[11:4]} + {8'h00, extend};

	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			pwm_on_out <= 1'b0;
		else
			pwm_on_out <= ({1'b0, pulse_cnt_in} < on_pulses);
	end

endmodule

`default_nettype wire

// File: rtl/twelve_channel_dimming_pwm.v
`timescale 1ns/1ps
`default_nettype none
`include "dimming_pwm_consts.vh"

module twelve_channel_dimming_pwm #(
	parameter REF_HZ = `REF_CLK_HZ
) (
	input wire ref_clk_in,
	input wire rst_n_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [7:0] reg_rdata_out,
	input wire fail_safe_in,
	input wire stored_curve_select_in,
	input wire [3:0] stored_rate_select_in,
	input wire [95:0] stored_duty_byte_in,
	input wire stored_address_use_in,
	input wire slave_select_timebase_pin_in,
	input wire slave_select_dim_in0_in,
	input wire slave_select_dim_in1_in,
	output reg [11:0] current_output_n_out
);

	reg [7:0] high_ff [0:11];
	reg [3:0] low_ff [0:11];
	reg [7:0] act_high_ff [0:11];
	reg [3:0] act_low_ff [0:11];
	reg curve_ff;
	reg common_ff;
	reg ext_sel_ff;
	reg [3:0] rate_ff;
	reg [11:0] en_ff;
	reg fail_prev_ff;
	reg [2:0] s1_ff;
	reg [2:0] s2_ff;
	reg [2:0] s3_ff;
	reg [2:0] filt_ff;
	reg clk_prev_ff;
	reg [15:0] div_cnt_ff;
	reg int_tick_ff;
	reg ext_tick_ff;
	reg [7:0] pulse_cnt_ff;
	reg [3:0] frame_ff;
	reg [7:0] nxt_rdata;
	wire [2:0] nxt_filt;
	wire [15:0] div_lim;
	wire use_ext;
	wire base_tick;
	wire period_wrap;
	wire reload;
	wire wr_high;
	wire wr_low;
	wire [11:0] pwm_on;
	integer i;
	integer j;

	// base pulse divider per rate code; endpoints 200 Hz and 20.8 kHz
	function [15:0] rate_div;
		input [3:0] sel;
		integer d;
		begin
			case (sel)
				4'h0: d = REF_HZ / (`PERIOD_PULSES * 200);
				4'h1: d = REF_HZ / (`PERIOD_PULSES * 250);
				4'h2: d = REF_HZ / (`PERIOD_PULSES * 300);
				4'h3: d = REF_HZ / (`PERIOD_PULSES * 400);
				4'h4: d = REF_HZ / (`PERIOD_PULSES * 500);
				4'h5: d = REF_HZ / (`PERIOD_PULSES * 600);
				4'h6: d = REF_HZ / (`PERIOD_PULSES * 800);
				4'h7: d = REF_HZ / (`PERIOD_PULSES * 1000);
				4'h8: d = REF_HZ / (`PERIOD_PULSES * 1200);
				4'h9: d = REF_HZ / (`PERIOD_PULSES * 1600);
				4'hA: d = REF_HZ / (`PERIOD_PULSES * 2000);
				4'hB: d = REF_HZ / (`PERIOD_PULSES * 2500);
				4'hC: d = REF_HZ / (`PERIOD_PULSES * 4000);
				4'hD: d = REF_HZ / (`PERIOD_PULSES * 6000);
				4'hE: d = REF_HZ / (`PERIOD_PULSES * 10000);
				default: d = REF_HZ / (`PERIOD_PULSES * 20800);
			endcase
			if (d < 1)
				d = 1;
			rate_div = d[15:0];
		end
	endfunction

	assign reload = !rst_n_in || (fail_safe_in && !fail_prev_ff);
	assign wr_high = reg_wr_in && (reg_addr_in[7:4] == 4'h0) && (reg_addr_in[3:0] < 4'hC);
	assign wr_low = reg_wr_in && (reg_addr_in[7:4] == 4'h1) && (reg_addr_in[3:0] < 4'hC);

	// duty bytes, curve and rate: loaded from stored copies at reset and on fail-safe entry; enables, common and ext bits reset only
	always @(posedge ref_clk_in)
	begin
		fail_prev_ff <= rst_n_in ? fail_safe_in : 1'b0;
		if (reload)
		begin
			for (i = 0; i < `NUM_CH; i = i + 1)
			begin
				high_ff[i] <= stored_duty_byte_in[8*i +: 8];
				low_ff[i] <= `LOW_NIBBLE_RESET;
				act_high_ff[i] <= stored_duty_byte_in[8*i +: 8];
				act_low_ff[i] <= `LOW_NIBBLE_RESET;
			end
			curve_ff <= stored_curve_select_in;
			rate_ff <= stored_rate_select_in;
			if (!rst_n_in)
			begin
				common_ff <= `CTRL_COMMON_RESET;
				ext_sel_ff <= `CTRL_EXT_RESET;
				en_ff <= `EN_RESET;
			end
		end
		else if (reg_wr_in)
		begin
			for (i = 0; i < `NUM_CH; i = i + 1)
			begin
				if (wr_low && reg_addr_in[3:0] == i)
					low_ff[i] <= reg_wdata_in[3:0];
				if (wr_high && reg_addr_in[3:0] == i)
				begin
					high_ff[i] <= reg_wdata_in;
					act_high_ff[i] <= reg_wdata_in;
					act_low_ff[i] <= low_ff[i];
				end
			end
			if (reg_addr_in == `ADDR_CTRL)
			begin
				curve_ff <= reg_wdata_in[`CTRL_CURVE_BIT];
				common_ff <= reg_wdata_in[`CTRL_COMMON_BIT];
				ext_sel_ff <= reg_wdata_in[`CTRL_EXT_BIT];
			end
			if (reg_addr_in == `ADDR_RATE)
				rate_ff <= reg_wdata_in[3:0];
			if (reg_addr_in == `ADDR_EN_LO)
				en_ff[7:0] <= reg_wdata_in;
			if (reg_addr_in == `ADDR_EN_HI)
				en_ff[11:8] <= reg_wdata_in[3:0];
		end
	end

	// read path, data valid in the cycle after the strobe only
	always @*
	begin
		nxt_rdata = 8'h00;
		for (j = 0; j < `NUM_CH; j = j + 1)
		begin
			if (reg_addr_in == `ADDR_HIGH_BASE + j)
				nxt_rdata = high_ff[j];
			if (reg_addr_in == `ADDR_LOW_BASE + j)
				nxt_rdata = {4'h0, low_ff[j]};
		end
		if (reg_addr_in == `ADDR_CTRL)
			nxt_rdata = {5'h00, ext_sel_ff, common_ff, curve_ff};
		if (reg_addr_in == `ADDR_RATE)
			nxt_rdata = {4'h0, rate_ff};
		if (reg_addr_in == `ADDR_EN_LO)
			nxt_rdata = en_ff[7:0];
		if (reg_addr_in == `ADDR_EN_HI)
			nxt_rdata = {4'h0, en_ff[11:8]};
		if (reg_addr_in == `ADDR_STATUS)
			nxt_rdata = {3'h0, use_ext, filt_ff[2], filt_ff[1], fail_safe_in,
				stored_address_use_in};
	end

	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			reg_rdata_out <= 8'h00;
		else if (reg_rd_in)
			reg_rdata_out <= nxt_rdata;
		else
			reg_rdata_out <= 8'h00;
	end

	// pin synchronisers: a level is accepted once stages two and three agree
	assign nxt_filt = (filt_ff & (s2_ff ^ s3_ff)) | (s3_ff & ~(s2_ff ^ s3_ff));

	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			s1_ff <= 3'h7;
			s2_ff <= 3'h7;
			s3_ff <= 3'h7;
			filt_ff <= 3'h7;
			clk_prev_ff <= 1'b1;
		end
		else
		begin
			s1_ff <= {slave_select_dim_in1_in, slave_select_dim_in0_in,
				slave_select_timebase_pin_in};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			filt_ff <= nxt_filt;
			clk_prev_ff <= filt_ff[0];
		end
	end

	// base pulse source; the external edge feeds only the PWM counters
	assign use_ext = ext_sel_ff && stored_address_use_in;
	assign div_lim = rate_div(rate_ff);

	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			div_cnt_ff <= 16'h0000;
			int_tick_ff <= 1'b0;
			ext_tick_ff <= 1'b0;
		end
		else
		begin
			if (div_cnt_ff + 16'h0001 >= div_lim)
				div_cnt_ff <= 16'h0000;
			else
				div_cnt_ff <= div_cnt_ff + 16'h0001;
			int_tick_ff <= (div_cnt_ff + 16'h0001 >= div_lim);
			ext_tick_ff <= filt_ff[0] && !clk_prev_ff;
		end
	end

	assign base_tick = use_ext ? ext_tick_ff : int_tick_ff;
	assign period_wrap = base_tick && (pulse_cnt_ff == 8'hFF);

	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			pulse_cnt_ff <= 8'h00;
			frame_ff <= 4'h0;
		end
		else if (base_tick)
		begin
			pulse_cnt_ff <= pulse_cnt_ff + 8'h01;
			if (period_wrap)
				frame_ff <= frame_ff + 4'h1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `NUM_CH; g = g + 1)
		begin : ch
			wire [7:0] src_high;
			wire [3:0] src_low;
			wire [11:0] exp_code;
			wire [11:0] duty_code;

			assign src_high = common_ff ? act_high_ff[0] : act_high_ff[g];
			assign src_low = common_ff ? act_low_ff[0] : act_low_ff[g];

			exp_curve_rom u_rom (
				.index_in(src_high),
				.code_out(exp_code)
			);

			// fail-safe nibble F gives exactly (byte+1)/256
			assign duty_code = fail_safe_in ? {stored_duty_byte_in[8*g +: 8], 4'hF} :
				curve_ff ? exp_code :
				{src_high, src_low};

			pwm_channel u_pwm (
				.ref_clk_in(ref_clk_in),
				.rst_n_in(rst_n_in),
				.period_wrap_in(period_wrap),
				.pulse_cnt_in(pulse_cnt_ff),
				.frame_in(frame_ff),
				.duty_code_in(duty_code),
				.pwm_on_out(pwm_on[g])
			);

			always @(posedge ref_clk_in)
			begin
				if (!rst_n_in)
					current_output_n_out[g] <= 1'b1;
				else
					current_output_n_out[g] <= !(en_ff[g] && pwm_on[g] &&
						(!stored_address_use_in || !filt_ff[(g < 6) ? 1 : 2]));
			end
		end
	endgenerate

endmodule

`default_nettype wire

// File: bench/ext_side.sv
`timescale 1ns/1ps
`default_nettype none
module ext_side (
	input wire logic run_in,
	input wire logic [1:0] dim_on_in,
	output logic tb_clk_out,
	output logic [1:0] dim_n_out
);
	// timebase stands low while not running; 4 ref cycles per base pulse
	always #8 tb_clk_out = run_in && !tb_clk_out;
	assign dim_n_out = ~dim_on_in;
endmodule
`default_nettype wire

// File: bench/pwm_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "dimming_pwm_consts.vh"
module pwm_checker (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic fail_safe_in,
	input wire logic stored_address_use_in,
	input wire logic slave_select_dim_in0_in,
	input wire logic slave_select_dim_in1_in,
	input wire logic [11:0] current_output_n_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	logic [11:0] en_ff;
	logic [2:0] off_ff;
	// shadow of enables; outputs lag them by a few cycles
	always_ff @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			en_ff <= 12'h000;
		else if (reg_wr_in && reg_addr_in == `ADDR_EN_LO)
			en_ff[7:0] <= reg_wdata_in;
		else if (reg_wr_in && reg_addr_in == `ADDR_EN_HI)
			en_ff[11:8] <= reg_wdata_in[3:0];
		if (!rst_n_in || en_ff != 12'h000)
			off_ff <= 3'h0;
		else if (off_ff != 3'h7)
			off_ff <= off_ff + 3'h1;
	end
	sequence hb_write;
		reg_wr_in && reg_addr_in < 8'h0C && !fail_safe_in;
	endsequence
	sequence hb_read;
		reg_rd_in && reg_addr_in == $past(reg_addr_in) && !fail_safe_in;
	endsequence
	sequence calm;
		!fail_safe_in && $stable(stored_address_use_in);
	endsequence
	rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data outside its slot");
	reset_dark_a: assert property ($rose(rst_n_in) |-> current_output_n_out == 12'hFFF)
		else $error("output on at reset release");
	disabled_dark_a: assert property (off_ff == 3'h7 |-> current_output_n_out == 12'hFFF)
		else $error("disabled channel conducts");
	dim0_dark_a: assert property ((stored_address_use_in && slave_select_dim_in0_in) [*8]
		|-> current_output_n_out[5:0] == 6'h3F)
		else $error("group 0 conducts with dim input high");
	dim1_dark_a: assert property ((stored_address_use_in && slave_select_dim_in1_in) [*8]
		|-> current_output_n_out[11:6] == 6'h3F)
		else $error("group 1 conducts with dim input high");
	high_readback_a: assert property (hb_write ##1 hb_read |=> reg_rdata_out == $past(reg_wdata_in, 2))
		else $error("high byte read back wrong");
	unmapped_zero_a: assert property (reg_rd_in && reg_addr_in > 8'h24 |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	status_level_a: assert property (calm [*4] ##0 (reg_rd_in && reg_addr_in == `ADDR_STATUS)
		|=> reg_rdata_out[1:0] == {1'h0, $past(stored_address_use_in)})
		else $error("status bits wrong");
endmodule
bind twelve_channel_dimming_pwm pwm_checker chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .fail_safe_in(fail_safe_in),
	.stored_address_use_in(stored_address_use_in),
	.slave_select_dim_in0_in(slave_select_dim_in0_in),
	.slave_select_dim_in1_in(slave_select_dim_in1_in),
	.current_output_n_out(current_output_n_out));
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dimming_pwm_consts.vh"
module tb;
	logic clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd = 1'h0, fs = 1'h0, au = 1'h0, run = 1'h0;
	logic [7:0] addr = 8'h00, wd = 8'h00;
	logic [1:0] dim_on = 2'h0;
	logic [95:0] sdb = {12{8'h1F}};
	wire logic [7:0] rdata;
	wire logic [11:0] outn;
	wire logic tbp;
	wire logic [1:0] dimn;
	int fails = 0, compares = 0;
	twelve_channel_dimming_pwm #(.REF_HZ(2560000)) dut (.ref_clk_in(clk), .rst_n_in(rst_n),
		.reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .fail_safe_in(fs), .stored_curve_select_in(1'h0),
		.stored_rate_select_in(4'hF), .stored_duty_byte_in(sdb), .stored_address_use_in(au),
		.slave_select_timebase_pin_in(tbp), .slave_select_dim_in0_in(dimn[0]),
		.slave_select_dim_in1_in(dimn[1]), .current_output_n_out(outn));
	ext_side far (.run_in(run), .dim_on_in(dim_on), .tb_clk_out(tbp), .dim_n_out(dimn));
	initial forever #2 clk = ~clk;
	task automatic end_of_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic bad(input string m);
		fails++;
		$display("BAD %0t %s", $time, m);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		rd <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		@(posedge clk);
		compares++;
		if (rdata !== e)
			bad("register read");
	endtask
	// counts conducting cycles over len cycles: a whole 16-period dither sequence, except two periods in the first call
	task automatic cnt_chk(input int ch, input int w, input int len, input int e);
		int n;
		n = 0;
		repeat (w) @(posedge clk);
		repeat (len)
		begin
			@(posedge clk);
			if (outn[ch] === 1'h0)
				n++;
			else if (outn[ch] !== 1'h1)
				n += len + 1;
		end
		compares++;
		if (n != e)
			bad("on-time count");
	endtask
	initial
	begin
		#360000;
		bad("timeout");
		end_of_test;
	end
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		rd_chk(`ADDR_HIGH_BASE, 8'h1F);
		rd_chk(`ADDR_LOW_BASE + 8'h05, 8'h0F);
		rd_chk(`ADDR_RATE, 8'h0F);
		rd_chk(8'h30, 8'h00);
		cnt_chk(0, 300, 512, 0);
		wr_reg(`ADDR_EN_LO, 8'hFF);
		wr_reg(`ADDR_EN_HI, 8'h0F);
		cnt_chk(0, 300, 4096, 512);
		wr_reg(`ADDR_LOW_BASE, 8'h03);
		cnt_chk(0, 300, 4096, 512);
		wr_reg(`ADDR_HIGH_BASE, 8'h10);
		rd_chk(`ADDR_HIGH_BASE, 8'h10);
		cnt_chk(0, 300, 4096, 260);
		wr_reg(`ADDR_LOW_BASE, 8'h00);
		wr_reg(`ADDR_HIGH_BASE, 8'h00);
		cnt_chk(0, 300, 4096, 1);
		wr_reg(`ADDR_CTRL, 8'h02);
		cnt_chk(1, 300, 4096, 1);
		wr_reg(`ADDR_LOW_BASE, 8'h0F);
		wr_reg(`ADDR_CTRL, 8'h01);
		cnt_chk(0, 300, 4096, 1);
		wr_reg(`ADDR_HIGH_BASE, 8'hFF);
		cnt_chk(0, 300, 4096, 4033);
		fs <= 1'h1;
		cnt_chk(0, 300, 4096, 512);
		fs <= 1'h0;
		rd_chk(`ADDR_CTRL, 8'h00);
		for (int k = 0; k < `NUM_CH; k++)
			wr_reg(`ADDR_HIGH_BASE + k[7:0], 8'hFF);
		au <= 1'h1;
		dim_on <= 2'h1;
		cnt_chk(0, 300, 4096, 4096);
		cnt_chk(6, 0, 4096, 0);
		rd_chk(`ADDR_STATUS, 8'h09);
		dim_on <= 2'h2;
		cnt_chk(6, 300, 4096, 4096);
		dim_on <= 2'h3;
		wr_reg(`ADDR_HIGH_BASE, 8'h1F);
		wr_reg(`ADDR_RATE, 8'h0C);
		cnt_chk(0, 600, 8192, 1024);
		wr_reg(`ADDR_CTRL, 8'h04);
		run <= 1'h1;
		cnt_chk(0, 1200, 16384, 2048);
		end_of_test;
	end
endmodule
`default_nettype wire
